// ==== design/audio_clock_pkg.sv ====
// constants and types shared by the audio master clock configuration block
package audio_clock_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_TX_CLOCK = 32'h8082_00a0;
  localparam logic [31:0] ADDR_RX_CLOCK = 32'h8082_00a4;
  localparam logic [31:0] ADDR_TX_LENGTH = 32'h8082_00a8;
  localparam logic [31:0] ADDR_RX_LENGTH = 32'h8082_00ac;
  localparam logic [31:0] ADDR_TX_ENABLE = 32'h8082_00b0;
  localparam logic [31:0] ADDR_RX_ENABLE = 32'h8082_00b4;
  localparam logic [31:0] ADDR_STATUS = 32'h8082_00b8;
  localparam logic [31:0] ADDR_DIVIDER = 32'h8093_008c;
  localparam logic [31:0] ADDR_DEVICE_CFG = 32'h8093_0080;

  // reset values
  localparam logic [4:0] SETTINGS_RESET = 5'h00;
  localparam logic [1:0] LENGTH_RESET = 2'h0;
  localparam logic [31:0] DIVIDER_RESET = 32'h0000_0000;
  localparam logic [31:0] DEVICE_CFG_RESET = 32'h0000_0000;
  localparam logic [6:0] CONFIG_RESET = 7'h00;

  // fields of a clock settings register
  localparam int SET_MASTER = 0;
  localparam int SET_POLARITY = 1;
  localparam int SET_NO_GATING = 2;
  localparam int SET_RATE_LO = 3;

  // fields of the configuration word
  localparam int CFG_MASTER = 0;
  localparam int CFG_LENGTH_LO = 1;
  localparam int CFG_POLARITY = 3;
  localparam int CFG_NO_GATING = 4;
  localparam int CFG_RATE_LO = 5;

  // fields of the divider override register
  localparam int DIV_BIT_DIVIDE = 16;
  localparam int DIV_WORD_DIVIDE_LO = 17;
  localparam int DIV_POLARITY = 19;
  localparam int DIV_DROP = 20;
  localparam int DIV_OVERRIDE = 29;
  localparam int DIV_SLAVE = 30;
  localparam int DIV_ENABLE = 31;

  // fields of the device configuration register
  localparam int DEV_CODEC_PINS = 6;
  localparam int DEV_SYNC_PINS = 7;

  // encodings
  localparam logic [1:0] LENGTH_16 = 2'h0;
  localparam logic [1:0] LENGTH_24 = 2'h1;
  localparam logic [1:0] RATE_BY_LENGTH = 2'h0;
  localparam logic [1:0] RATIO_32 = 2'h0;
  localparam logic [1:0] RATIO_64 = 2'h1;
  localparam logic [1:0] RATIO_128 = 2'h2;
  localparam logic [4:0] FIRST_GATED_SLOT = 5'h18;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_RUN = 2'b10
  } gen_state_t;

endpackage

// ==== design/clock_pattern_gen.sv ====
// bit clock and word clock pattern generator running off the master clock
`timescale 1ns/100ps
`default_nettype none
module clock_pattern_gen #(
  parameter int COUNT_WIDTH = 7
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic divide_by_four,
  input wire logic [1:0] ratio,
  input wire logic gate_tail,
  input wire logic polarity,
  output logic bit_clock,
  output logic word_clock
);

  if (COUNT_WIDTH < 7)
    $error("clock_pattern_gen: COUNT_WIDTH must cover 128 bits per frame");

  audio_clock_pkg::gen_state_t state, next_state;
  logic phase, next_phase;
  logic sclk, next_sclk;
  logic [COUNT_WIDTH-1:0] count, next_count;
  logic [COUNT_WIDTH-1:0] frame_last;
  logic word_bit;
  logic suppress;
  logic next_bit_clock, next_word_clock;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (ratio)
      audio_clock_pkg::RATIO_32:
      begin
        frame_last = COUNT_WIDTH'(31);
        word_bit = count[4];
      end
      audio_clock_pkg::RATIO_64:
      begin
        frame_last = COUNT_WIDTH'(63);
        word_bit = count[5];
      end
      default:
      begin
        frame_last = COUNT_WIDTH'(127);
        word_bit = count[6];
      end
    endcase
    // tail of each 32-slot word is held off in the 64x gated mode
    suppress = gate_tail && (ratio == audio_clock_pkg::RATIO_64) &&
      (count[4:0] >= audio_clock_pkg::FIRST_GATED_SLOT); // RULE14
  end

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_sclk = sclk;
    next_count = count;
    case (state)
      audio_clock_pkg::GEN_IDLE:
      begin
        next_phase = 1'b0;
        next_sclk = 1'b0;
        next_count = '0;
        if (run)
          next_state = audio_clock_pkg::GEN_RUN;
      end
      audio_clock_pkg::GEN_RUN:
      begin
        if (!run)
        begin
          next_state = audio_clock_pkg::GEN_IDLE;
          next_phase = 1'b0;
          next_sclk = 1'b0;
          next_count = '0;
        end
        else if (!divide_by_four || phase)
        begin
          // half the master clock unless the override divides further
          next_phase = 1'b0; // RULE9
          next_sclk = ~sclk;
          // word clock moves only on the internal falling edge
          if (sclk)
            next_count = (count == frame_last) ? '0 : count + 1'b1;
        end
        else
          next_phase = 1'b1;
      end
      default:
        next_state = audio_clock_pkg::GEN_IDLE;
    endcase
    if (state == audio_clock_pkg::GEN_RUN)
    begin
      next_bit_clock = (sclk & ~suppress) ^ polarity;
      next_word_clock = word_bit;
    end
    else
    begin
      next_bit_clock = 1'b0;
      next_word_clock = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state <= audio_clock_pkg::GEN_IDLE;
      phase <= 1'b0;
      sclk <= 1'b0;
      count <= '0;
      bit_clock <= 1'b0;
      word_clock <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      sclk <= next_sclk;
      count <= next_count;
      bit_clock <= next_bit_clock;
      word_clock <= next_word_clock;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_half_rate: assert property (@(posedge clock) disable iff (reset) // RULE9
    (state == audio_clock_pkg::GEN_RUN && $past(state) == state &&
     !$past(divide_by_four) && !gate_tail && !$past(gate_tail) &&
     $stable(polarity) && run)
    |=> bit_clock != $past(bit_clock))
    else $error("bit clock does not run at half the master clock");

  a_tail_gated: assert property (@(posedge clock) disable iff (reset) // RULE14
    (state == audio_clock_pkg::GEN_RUN && gate_tail &&
     ratio == audio_clock_pkg::RATIO_64 &&
     count[4:0] >= audio_clock_pkg::FIRST_GATED_SLOT)
    |=> bit_clock == $past(polarity))
    else $error("bit clock pulse not suppressed in word tail");

  c_gated_tail: cover property (@(posedge clock) disable iff (reset)
    state == audio_clock_pkg::GEN_RUN && suppress);

endmodule
`default_nettype wire

// ==== design/audio_master_clock_config.sv ====
// audio master clock configuration word, override selection and clocks
// Summary of operation
// (RULE1) word: master 0, length 2:1, polarity 3, no-gating 4, rate 6:5
// (RULE2) word comes from transmit or receive settings and length registers
// (RULE3) transmitter enabled: every word bit comes from transmit settings
// (RULE4) software keeps receive settings and length equal to transmit ones
// (RULE5) transmitter off: word built from receive settings and receive length; code ANDs the master bit with rx_enable
// (RULE6) both directions master share one bit clock and word clock
// (RULE7) divider bit 29 picks override fields or the configuration word
// (RULE8) override fields: polarity 19, drop 20, divide 16, word 18:17, 30, 31
// (RULE9) no override: bit clock is master/2, gated only for 24-bit rate 0
// (RULE10) no override: polarity bit3, word speed bits6:5, master bit0
// (RULE11) no override: clocks enabled by codec-pins or sync-serial-pins bit
// (RULE12) override: data edge falling for polarity 1, rising for polarity 0
// (RULE13) no override: data changes half a bit clock after aligned edge
// (RULE14) 24-bit gated: 64x bit clock, last 8 pulses of each word dropped
// (RULE15) word is registered and changes only when its sources change
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none
module audio_master_clock_config #(
  parameter int COUNT_WIDTH = 7
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  output logic [6:0] clock_config,
  output logic bit_clock,
  output logic word_select_clock,
  output logic clocks_active,
  output logic data_on_falling_edge
);

  //////////////////////////////////////////////////////////////////////////
  // software registers
  logic [4:0] transmit_clock_settings, next_transmit_clock_settings;
  logic [4:0] receive_clock_settings, next_receive_clock_settings;
  logic [1:0] tx_word_length, next_tx_word_length;
  logic [1:0] rx_word_length, next_rx_word_length;
  logic tx_enable, next_tx_enable;
  logic rx_enable, next_rx_enable;
  logic [31:0] audio_clock_divider_override;
  logic [31:0] next_audio_clock_divider_override;
  logic [31:0] device_configuration, next_device_configuration;
  logic [31:0] next_read_data;

  always_comb
  begin
    next_transmit_clock_settings = transmit_clock_settings;
    next_receive_clock_settings = receive_clock_settings;
    next_tx_word_length = tx_word_length;
    next_rx_word_length = rx_word_length;
    next_tx_enable = tx_enable;
    next_rx_enable = rx_enable;
    next_audio_clock_divider_override = audio_clock_divider_override;
    next_device_configuration = device_configuration;
    if (write_strobe)
    begin
      case (address)
        audio_clock_pkg::ADDR_TX_CLOCK:
          next_transmit_clock_settings = write_data[4:0];
        audio_clock_pkg::ADDR_RX_CLOCK:
          next_receive_clock_settings = write_data[4:0];
        audio_clock_pkg::ADDR_TX_LENGTH:
          next_tx_word_length = write_data[1:0];
        audio_clock_pkg::ADDR_RX_LENGTH:
          next_rx_word_length = write_data[1:0];
        audio_clock_pkg::ADDR_TX_ENABLE:
          next_tx_enable = write_data[0];
        audio_clock_pkg::ADDR_RX_ENABLE:
          next_rx_enable = write_data[0];
        audio_clock_pkg::ADDR_DIVIDER:
          next_audio_clock_divider_override = write_data;
        audio_clock_pkg::ADDR_DEVICE_CFG:
          next_device_configuration = write_data;
        default:
          next_tx_enable = tx_enable;
      endcase
    end
    // read data stand for exactly one cycle, unmapped reads give zero
    next_read_data = 32'h0000_0000;
    if (read_strobe)
    begin
      case (address)
        audio_clock_pkg::ADDR_TX_CLOCK:
          next_read_data = {27'h0, transmit_clock_settings};
        audio_clock_pkg::ADDR_RX_CLOCK:
          next_read_data = {27'h0, receive_clock_settings};
        audio_clock_pkg::ADDR_TX_LENGTH:
          next_read_data = {30'h0, tx_word_length};
        audio_clock_pkg::ADDR_RX_LENGTH:
          next_read_data = {30'h0, rx_word_length};
        audio_clock_pkg::ADDR_TX_ENABLE:
          next_read_data = {31'h0, tx_enable};
        audio_clock_pkg::ADDR_RX_ENABLE:
          next_read_data = {31'h0, rx_enable};
        audio_clock_pkg::ADDR_DIVIDER:
          next_read_data = audio_clock_divider_override;
        audio_clock_pkg::ADDR_DEVICE_CFG:
          next_read_data = device_configuration;
        audio_clock_pkg::ADDR_STATUS:
          next_read_data = {21'h0, data_on_falling_edge, clocks_active,
            word_select_clock, bit_clock, clock_config};
        default:
          next_read_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      transmit_clock_settings <= audio_clock_pkg::SETTINGS_RESET;
      receive_clock_settings <= audio_clock_pkg::SETTINGS_RESET;
      tx_word_length <= audio_clock_pkg::LENGTH_RESET;
      rx_word_length <= audio_clock_pkg::LENGTH_RESET;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      audio_clock_divider_override <= audio_clock_pkg::DIVIDER_RESET;
      device_configuration <= audio_clock_pkg::DEVICE_CFG_RESET;
      read_data <= 32'h0000_0000;
    end
    else
    begin
      transmit_clock_settings <= next_transmit_clock_settings;
      receive_clock_settings <= next_receive_clock_settings;
      tx_word_length <= next_tx_word_length;
      rx_word_length <= next_rx_word_length;
      tx_enable <= next_tx_enable;
      rx_enable <= next_rx_enable;
      audio_clock_divider_override <= next_audio_clock_divider_override;
      device_configuration <= next_device_configuration;
      read_data <= next_read_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration word
  logic [6:0] tx_word, rx_word, next_clock_config;

  always_comb
  begin
    tx_word = {transmit_clock_settings[audio_clock_pkg::SET_RATE_LO +: 2],
      transmit_clock_settings[audio_clock_pkg::SET_NO_GATING],
      transmit_clock_settings[audio_clock_pkg::SET_POLARITY],
      tx_word_length,
      transmit_clock_settings[audio_clock_pkg::SET_MASTER]}; // RULE1
    // master bit drops while both channels are off so without the override no clock runs idle
    rx_word = {receive_clock_settings[audio_clock_pkg::SET_RATE_LO +: 2],
      receive_clock_settings[audio_clock_pkg::SET_NO_GATING],
      receive_clock_settings[audio_clock_pkg::SET_POLARITY],
      rx_word_length,
      receive_clock_settings[audio_clock_pkg::SET_MASTER] & rx_enable};
    // transmitter wins whenever enabled; receiver must mirror it
    if (tx_enable) // RULE3
      next_clock_config = tx_word; // RULE2
    else
      next_clock_config = rx_word; // RULE5
  end

  // registered word; a new value only follows a source change
  always_ff @(posedge clock)
  begin
    if (reset)
      clock_config <= audio_clock_pkg::CONFIG_RESET;
    else
      clock_config <= next_clock_config; // RULE15
  end

  //////////////////////////////////////////////////////////////////////////
  // clock generator controls: override fields or configuration word
  logic override;
  logic gen_enable, gen_master, gen_run, eff_polarity, divide_by_four;
  logic gate_tail;
  logic [1:0] ratio;
  logic [1:0] cfg_rate;

  always_comb
  begin
    override = audio_clock_divider_override[audio_clock_pkg::DIV_OVERRIDE];
    cfg_rate = clock_config[audio_clock_pkg::CFG_RATE_LO +: 2];
    if (override) // RULE7
    begin
      gen_enable =
        audio_clock_divider_override[audio_clock_pkg::DIV_ENABLE]; // RULE8
      gen_master =
        !audio_clock_divider_override[audio_clock_pkg::DIV_SLAVE];
      eff_polarity =
        audio_clock_divider_override[audio_clock_pkg::DIV_POLARITY];
      divide_by_four =
        audio_clock_divider_override[audio_clock_pkg::DIV_BIT_DIVIDE];
      gate_tail = audio_clock_divider_override[audio_clock_pkg::DIV_DROP];
      case (audio_clock_divider_override
            [audio_clock_pkg::DIV_WORD_DIVIDE_LO +: 2])
        2'h0: ratio = audio_clock_pkg::RATIO_32;
        2'h1: ratio = audio_clock_pkg::RATIO_64;
        default: ratio = audio_clock_pkg::RATIO_128;
      endcase
    end
    else
    begin
      gen_enable =
        device_configuration[audio_clock_pkg::DEV_CODEC_PINS] |
        device_configuration[audio_clock_pkg::DEV_SYNC_PINS]; // RULE11
      gen_master = clock_config[audio_clock_pkg::CFG_MASTER]; // RULE10
      eff_polarity = clock_config[audio_clock_pkg::CFG_POLARITY];
      divide_by_four = 1'b0; // RULE9
      gate_tail = !clock_config[audio_clock_pkg::CFG_NO_GATING] &&
        cfg_rate == audio_clock_pkg::RATE_BY_LENGTH &&
        clock_config[audio_clock_pkg::CFG_LENGTH_LO +: 2] ==
        audio_clock_pkg::LENGTH_24; // RULE9
      case (cfg_rate)
        audio_clock_pkg::RATE_BY_LENGTH:
          ratio = (clock_config[audio_clock_pkg::CFG_LENGTH_LO +: 2] ==
            audio_clock_pkg::LENGTH_16) ? audio_clock_pkg::RATIO_32 :
            audio_clock_pkg::RATIO_64;
        2'h1: ratio = audio_clock_pkg::RATIO_32;
        2'h2: ratio = audio_clock_pkg::RATIO_64;
        default: ratio = audio_clock_pkg::RATIO_128; // RULE10
      endcase
    end
    // one generator serves both directions
    gen_run = gen_enable & gen_master; // RULE6
  end

  // word clock moves on the internal falling edge, so data take the
  // opposite edge of the output bit clock
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      clocks_active <= 1'b0;
      data_on_falling_edge <= 1'b0;
    end
    else
    begin
      clocks_active <= gen_run;
      data_on_falling_edge <= eff_polarity; // RULE12 RULE13
    end
  end

  clock_pattern_gen #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) pattern (
    .clock(clock),
    .reset(reset),
    .run(gen_run),
    .divide_by_four(divide_by_four),
    .ratio(ratio),
    .gate_tail(gate_tail),
    .polarity(eff_polarity),
    .bit_clock(bit_clock),
    .word_clock(word_select_clock)
  );

  //////////////////////////////////////////////////////////////////////////
  a_tx_source: assert property (@(posedge clock) disable iff (reset) // RULE3
    tx_enable |=> clock_config == $past(tx_word))
    else $error("word not taken from transmit settings");

  a_rx_source: assert property (@(posedge clock) disable iff (reset) // RULE5
    (!tx_enable && rx_enable) |=> clock_config == $past(rx_word))
    else $error("word not taken from receive settings");

  a_length_field: assert property (@(posedge clock) // RULE1
    disable iff (reset)
    (tx_enable && tx_word_length == audio_clock_pkg::LENGTH_24)
    |=> clock_config[2:1] == audio_clock_pkg::LENGTH_24 &&
        clock_config[6:5] == $past(transmit_clock_settings[4:3]))
    else $error("configuration word fields misplaced");

  a_word_stable: assert property (@(posedge clock) // RULE15
    disable iff (reset)
    ($stable(transmit_clock_settings) && $stable(receive_clock_settings) &&
     $stable(tx_word_length) && $stable(rx_word_length) &&
     $stable(tx_enable) && $stable(rx_enable))
    |=> $stable(clock_config))
    else $error("configuration word changed without cause");

  a_select_word: assert property (@(posedge clock) disable iff (reset) // RULE7
    (!override && device_configuration[audio_clock_pkg::DEV_CODEC_PINS] &&
     clock_config[0])
    |=> clocks_active)
    else $error("clocks not started from configuration word");

  a_override_off: assert property (@(posedge clock) // RULE8
    disable iff (reset)
    (override && (!audio_clock_divider_override[31] ||
      audio_clock_divider_override[30]))
    |=> !clocks_active)
    else $error("override enable or slave select ignored");

  a_pin_enable: assert property (@(posedge clock) disable iff (reset) // RULE11
    (!override && !device_configuration[6] && !device_configuration[7])
    |=> !clocks_active)
    else $error("clocks run without a pin routing bit");

  a_shared_clock: assert property (@(posedge clock) // RULE6
    disable iff (reset)
    (tx_enable && rx_enable && !override && clock_config[0])
    |=> clock_config == $past(tx_word))
    else $error("directions do not share one clock set");

  a_edge_override: assert property (@(posedge clock) // RULE12
    disable iff (reset)
    (override && audio_clock_divider_override[19] != clock_config[3])
    |=> data_on_falling_edge == $past(audio_clock_divider_override[19]))
    else $error("override data edge wrong");

  a_edge_config: assert property (@(posedge clock) // RULE13
    disable iff (reset)
    !override |=> data_on_falling_edge == $past(clock_config[3]))
    else $error("data edge not opposite the aligned edge");

  c_tx_master: cover property (@(posedge clock) disable iff (reset)
    tx_enable && clocks_active);
  c_rx_only: cover property (@(posedge clock) disable iff (reset)
    !tx_enable && rx_enable && clocks_active);
  c_override_run: cover property (@(posedge clock) disable iff (reset)
    override && clocks_active);

endmodule
`default_nettype wire

// ==== bench/audio_clock_sink.sv ====
// far-side clock receiver model: counts bit clock pulses per word half
`timescale 1ns/100ps
`default_nettype none
module audio_clock_sink (
  input wire logic clock,
  input wire logic reset,
  input wire logic bit_clock,
  input wire logic word_select_clock,
  output logic [7:0] pulses_per_half,
  output logic [3:0] bit_period,
  output logic half_done
);
  logic [7:0] count;
  logic [3:0] since_rise;
  logic bit_last;
  logic word_last;
  logic rise;
  logic turn;
  assign rise = bit_clock && !bit_last;
  assign turn = word_select_clock != word_last;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count <= 8'h00;
      since_rise <= 4'h0;
      bit_last <= 1'b0;
      word_last <= 1'b0;
      half_done <= 1'b0;
      pulses_per_half <= 8'h00;
      bit_period <= 4'h0;
    end
    else
    begin
      bit_last <= bit_clock;
      word_last <= word_select_clock;
      half_done <= turn;
      // saturate so a long gated gap never wraps into a false period
      if (rise)
        since_rise <= 4'h1;
      else if (since_rise != 4'hf)
        since_rise <= since_rise + 4'h1;
      // a rise that meets a word edge opens the new half, no period
      if (rise && !turn && count != 8'h00)
        bit_period <= since_rise;
      if (turn)
      begin
        pulses_per_half <= count;
        count <= {7'h00, rise};
      end
      else
        count <= count + {7'h00, rise};
    end
  end
endmodule
`default_nettype wire

// ==== bench/audio_master_clock_config_tb.sv ====
// self-checking bench for the audio master clock configuration block
`timescale 1ns/100ps
`default_nettype none
module audio_master_clock_config_tb;
  typedef struct {logic [31:0] value; logic [31:0] mask;} note_t;
  typedef struct {logic [4:0] set; logic [1:0] len; logic [7:0] dev;
    logic [31:0] div; logic [7:0] pulses; logic [3:0] period;
    logic falling; logic active;} case_t;
  logic clock;
  logic reset;
  logic [31:0] address;
  logic [31:0] write_data;
  logic write_strobe;
  logic read_strobe;
  logic [31:0] read_data;
  logic [6:0] clock_config;
  logic bit_clock;
  logic word_select_clock;
  logic clocks_active;
  logic data_on_falling_edge;
  logic [7:0] pulses_per_half;
  logic [3:0] bit_period;
  logic half_done;
  logic read_due;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  note_t notes[$];
  note_t n;
  case_t cases [13] = '{
    '{5'h01, 2'h0, 8'h40, 32'h0, 8'h10, 4'h2, 1'b0, 1'b1},
    '{5'h01, 2'h1, 8'h80, 32'h0, 8'h18, 4'h2, 1'b0, 1'b1},
    '{5'h05, 2'h1, 8'h40, 32'h0, 8'h20, 4'h2, 1'b0, 1'b1},
    '{5'h01, 2'h2, 8'h80, 32'h0, 8'h20, 4'h2, 1'b0, 1'b1},
    '{5'h09, 2'h1, 8'h40, 32'h0, 8'h10, 4'h2, 1'b0, 1'b1},
    '{5'h13, 2'h0, 8'h80, 32'h0, 8'h20, 4'h2, 1'b1, 1'b1},
    '{5'h19, 2'h0, 8'h40, 32'h0, 8'h40, 4'h2, 1'b0, 1'b1},
    '{5'h01, 2'h0, 8'h00, 32'h0, 8'h00, 4'h0, 1'b0, 1'b0},
    '{5'h00, 2'h0, 8'h40, 32'h0, 8'h00, 4'h0, 1'b0, 1'b0},
    '{5'h19, 2'h0, 8'h00, 32'ha01b_0000, 8'h18, 4'h4, 1'b1, 1'b1},
    '{5'h03, 2'h0, 8'h00, 32'ha004_0000, 8'h40, 4'h2, 1'b0, 1'b1},
    '{5'h01, 2'h0, 8'h00, 32'ha000_0000, 8'h10, 4'h2, 1'b0, 1'b1},
    '{5'h01, 2'h0, 8'h40, 32'he000_0000, 8'h00, 4'h0, 1'b0, 1'b0}};

  audio_master_clock_config audio_master_clock_config_i (
    .clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .clock_config(clock_config), .bit_clock(bit_clock),
    .word_select_clock(word_select_clock), .clocks_active(clocks_active),
    .data_on_falling_edge(data_on_falling_edge));
  audio_clock_sink audio_clock_sink_i (
    .clock(clock), .reset(reset), .bit_clock(bit_clock),
    .word_select_clock(word_select_clock),
    .pulses_per_half(pulses_per_half), .bit_period(bit_period),
    .half_done(half_done));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic bus_read(input logic [31:0] a, input logic [31:0] v,
    input logic [31:0] m);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    notes.push_back('{v, m});
    @(posedge clock);
    read_strobe <= 1'b0;
  endtask
  task automatic wait_half;
    int k;
    k = 0;
    @(negedge clock);
    while (half_done !== 1'b1 && k < 600)
    begin
      @(negedge clock);
      k++;
    end
    check({31'h0, half_done}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    read_due <= read_strobe;
    cycles++;
    // generous: the clock table needs well under half of this
    if (cycles == 30000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge clock)
  begin
    if (read_due === 1'b1)
    begin
      n = notes.pop_front();
      check(read_data & n.mask, n.value);
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [4:0] ts;
    logic [4:0] rs;
    logic [1:0] tl;
    logic [1:0] rl;
    logic re;
    logic [6:0] w;
    case_t c;
    reset = 1'b1;
    address = 32'h0;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    void'($urandom(99836));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    bus_read(audio_clock_pkg::ADDR_STATUS, 32'h0, 32'hffff_ffff);
    bus_read(audio_clock_pkg::ADDR_DIVIDER, 32'h0, 32'hffff_ffff);
    d = $urandom;
    bus_write(audio_clock_pkg::ADDR_DIVIDER, d);
    bus_read(audio_clock_pkg::ADDR_DIVIDER, d, 32'hffff_ffff);
    bus_write(audio_clock_pkg::ADDR_TX_CLOCK, d);
    bus_read(audio_clock_pkg::ADDR_TX_CLOCK, {27'h0, d[4:0]}, '1);
    bus_write(32'h8082_00fc, d);
    bus_read(32'h8082_00fc, 32'h0, 32'hffff_ffff);
    for (int i = 0; i < 8; i++)
    begin
      ts = 5'($urandom);
      rs = 5'($urandom);
      tl = 2'($urandom_range(2));
      rl = 2'($urandom_range(2));
      re = 1'($urandom);
      bus_write(audio_clock_pkg::ADDR_TX_CLOCK, {27'h0, ts});
      bus_write(audio_clock_pkg::ADDR_RX_CLOCK, {27'h0, rs});
      bus_write(audio_clock_pkg::ADDR_TX_LENGTH, {30'h0, tl});
      bus_write(audio_clock_pkg::ADDR_RX_LENGTH, {30'h0, rl});
      bus_write(audio_clock_pkg::ADDR_TX_ENABLE, {31'h0, i[0]});
      bus_write(audio_clock_pkg::ADDR_RX_ENABLE, {31'h0, re});
      w = i[0] ? {ts[4:1], tl, ts[0]} : {rs[4:1], rl, rs[0] & re};
      repeat (3) @(negedge clock);
      check({25'h0, clock_config}, {25'h0, w});
      bus_read(audio_clock_pkg::ADDR_STATUS, {25'h0, w}, 32'h7f);
      bus_write(audio_clock_pkg::ADDR_DIVIDER, 32'($urandom));
      repeat (3) @(negedge clock);
      check({25'h0, clock_config}, {25'h0, w});
    end
    foreach (cases[k])
    begin
      c = cases[k];
      bus_write(audio_clock_pkg::ADDR_TX_ENABLE, 32'h0);
      bus_write(audio_clock_pkg::ADDR_RX_ENABLE, 32'h0);
      bus_write(audio_clock_pkg::ADDR_TX_CLOCK, {27'h0, c.set});
      bus_write(audio_clock_pkg::ADDR_RX_CLOCK, {27'h0, c.set});
      bus_write(audio_clock_pkg::ADDR_TX_LENGTH, {30'h0, c.len});
      bus_write(audio_clock_pkg::ADDR_RX_LENGTH, {30'h0, c.len});
      bus_write(audio_clock_pkg::ADDR_DIVIDER, c.div);
      bus_write(audio_clock_pkg::ADDR_DEVICE_CFG, {24'h0, c.dev});
      bus_write(audio_clock_pkg::ADDR_TX_ENABLE, 32'h1);
      bus_write(audio_clock_pkg::ADDR_RX_ENABLE, 32'h1);
      repeat (4) @(negedge clock);
      check({31'h0, clocks_active}, {31'h0, c.active});
      if (c.active)
      begin
        repeat (3) wait_half;
        check({24'h0, pulses_per_half}, {24'h0, c.pulses});
        check({28'h0, bit_period}, {28'h0, c.period});
        check({31'h0, data_on_falling_edge},
          {31'h0, c.falling});
      end
      else
      begin
        repeat (40)
        begin
          @(negedge clock);
          check({31'h0, bit_clock}, 32'h0);
        end
      end
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
